// ===== src/swc_pkg.sv
package swc_pkg;

  // timing
  localparam int          CLK_HZ          = 50_000_000;
  localparam int          BTN_LONG_SEC    = 7;
  localparam int unsigned BTN_LONG_CYCLES = BTN_LONG_SEC * CLK_HZ;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CMD      = 8'h04;
  localparam logic [7:0] OFS_STATE    = 8'h08;
  localparam logic [7:0] OFS_EV_STAT  = 8'h0C;
  localparam logic [7:0] OFS_EV_CLR   = 8'h10;
  localparam logic [7:0] OFS_EV_EN    = 8'h14;
  localparam logic [7:0] OFS_TACH     = 8'h18;

  // control register fields
  localparam int CTRL_W          = 7;
  localparam int CTRL_SOFT_OFF   = 0;
  localparam int CTRL_ACPI       = 1;
  localparam int CTRL_ONBOARD    = 2;
  localparam int CTRL_MODEM_UNM  = 3;
  localparam int CTRL_BTN_S3     = 4;
  localparam int CTRL_REC_LO     = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h0A;

  // power-failure recovery policy
  localparam logic [1:0] REC_OFF  = 2'h0;
  localparam logic [1:0] REC_ON   = 2'h1;
  localparam logic [1:0] REC_LAST = 2'h2;

  // software commands
  localparam logic [2:0] CMD_S1     = 3'h1;
  localparam logic [2:0] CMD_S3     = 3'h2;
  localparam logic [2:0] CMD_OFF    = 3'h3;
  localparam logic [2:0] CMD_LEGACY = 3'h4;

  // event bits
  localparam int EV_W    = 8;
  localparam int EV_USB  = 0;
  localparam int EV_KBD  = 1;
  localparam int EV_PME  = 2;
  localparam int EV_RTC  = 3;
  localparam int EV_RING = 4;
  localparam int EV_NET  = 5;
  localparam int EV_BTN  = 6;
  localparam int EV_MAIN = 7;

  // the only slot whose PME may wake from soft-off (second slot, zero based)
  localparam int PME_S5_SLOT = 1;

  typedef enum logic [5:0] {
    ST_WORK   = 6'h01,
    ST_S1     = 6'h02,
    ST_S3     = 6'h04,
    ST_OFF    = 6'h08,
    ST_LEGACY = 6'h10,
    ST_LOST   = 6'h20
  } pstate_type;

endpackage : swc_pkg

// ===== src/btn_if.sv
interface btn_if;
  logic short_press;
  logic long_press;
  modport drv (output short_press, output long_press);
  modport sink (input short_press, input long_press);
endinterface : btn_if

// ===== src/pwr_button_timer.sv
module pwr_button_timer #(
  parameter int unsigned LONG_CYCLES = swc_pkg::BTN_LONG_CYCLES
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // button, low while pressed
  input  wire logic btn_n_in,
  // press classification
  btn_if.drv        evt
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        held;
    logic        fired;
    logic        short_p;
    logic        long_p;
  } tmr_type;

  tmr_type s_q;
  tmr_type s_d;

  always_comb begin
    s_d         = s_q;
    s_d.short_p = 1'b0;
    s_d.long_p  = 1'b0;
    if (!btn_n_in) begin
      s_d.held = 1'b1;
      if (!s_q.fired) begin
        // long press fires while still held, so release adds nothing
        if (s_q.cnt == 32'(LONG_CYCLES - 1)) begin
          s_d.long_p = 1'b1;
          s_d.fired  = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 32'h1;
        end
      end
    end else begin
      s_d.short_p = s_q.held & ~s_q.fired;
      s_d.held    = 1'b0;
      s_d.fired   = 1'b0;
      s_d.cnt     = 32'h0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign evt.short_press = s_q.short_p;
  assign evt.long_press  = s_q.long_p;

endmodule : pwr_button_timer

// ===== src/sleep_wake_event_control.sv
module sleep_wake_event_control #(
  parameter int unsigned BTN_LONG_CYCLES = swc_pkg::BTN_LONG_CYCLES,
  parameter int          NUM_PME_SLOTS   = 4
) (
  // clock and reset
  input  wire logic                     CLK_IN,
  input  wire logic                     RSTN_IN,
  // register port
  input  wire logic [7:0]               ADDR_IN,
  input  wire logic [31:0]              WDATA_IN,
  input  wire logic                     WR_IN,
  input  wire logic                     RD_IN,
  output logic      [31:0]              RDATA_OUT,
  // wake sources
  input  wire logic                     USB_ACT_IN,
  input  wire logic                     KBD_ACT_IN,
  input  wire logic [NUM_PME_SLOTS-1:0] PME_N_IN,
  input  wire logic                     RTC_ALARM_IN,
  input  wire logic                     RING_IN,
  input  wire logic                     NET_HDR_WAKE_IN,
  input  wire logic                     NET_ONBOARD_WAKE_IN,
  input  wire logic                     PWR_BTN_N_IN,
  // supply and board
  input  wire logic                     MAINS_OK_IN,
  input  wire logic                     LED_DUAL_IN,
  input  wire logic                     CPU_TACH_IN,
  input  wire logic                     SYS_TACH_IN,
  // power outputs
  output logic                          PSU_ON_OUT,
  output logic                          SYS_FAN_OUT,
  output logic                          CHASSIS_FAN_OUT,
  output logic                          LED_GREEN_OUT,
  output logic                          LED_AMBER_OUT,
  // interrupt
  output logic                          IRQ_OUT
);

  typedef struct packed {
    swc_pkg::pstate_type           state;
    logic                          prev_on;
    logic [swc_pkg::CTRL_W-1:0]    ctrl;
    logic [swc_pkg::EV_W-1:0]      ev_stat;
    logic [swc_pkg::EV_W-1:0]      ev_en;
    logic [31:0]                   rdata;
    logic                          cpu_tach;
    logic                          sys_tach;
    logic [15:0]                   cpu_cnt;
    logic [15:0]                   sys_cnt;
  } ctl_type;

  localparam ctl_type RESET_S = '{
    state:    swc_pkg::ST_LOST,
    prev_on:  1'b0,
    ctrl:     swc_pkg::CTRL_RESET,
    ev_stat:  8'h00,
    ev_en:    8'h00,
    rdata:    32'h0,
    cpu_tach: 1'b0,
    sys_tach: 1'b0,
    cpu_cnt:  16'h0,
    sys_cnt:  16'h0
  };

  localparam logic [5:0] SET_SLEEP_ACPI = swc_pkg::ST_S1 | swc_pkg::ST_S3;
  localparam logic [5:0] SET_ACPI_S5    = SET_SLEEP_ACPI | swc_pkg::ST_OFF;
  localparam logic [5:0] SET_ANY_SLEEP  = SET_ACPI_S5 | swc_pkg::ST_LEGACY;
  localparam logic [5:0] SET_RING       = swc_pkg::ST_S1 | swc_pkg::ST_LEGACY;
  localparam logic [5:0] SET_PSU_ON     = swc_pkg::ST_WORK | SET_RING;

  function automatic logic in_set(input swc_pkg::pstate_type st, input logic [5:0] set);
    in_set = |(st & set);
  endfunction : in_set

  ctl_type                  s_q;
  ctl_type                  s_d;
  logic [swc_pkg::EV_W-1:0] wake;
  logic                     pme_any;
  logic                     pme_s5;
  logic [1:0]               rec;
  logic                     restore_on;

  btn_if b ();

  pwr_button_timer #(
    .LONG_CYCLES (BTN_LONG_CYCLES)
  ) u_btn (
    .clk_in   (CLK_IN),
    .rstn_in  (RSTN_IN),
    .btn_n_in (PWR_BTN_N_IN),
    .evt      (b)
  );

  assign pme_any    = |(~PME_N_IN);
  assign pme_s5     = ~PME_N_IN[swc_pkg::PME_S5_SLOT];
  assign rec        = s_q.ctrl[swc_pkg::CTRL_REC_LO +: 2];
  assign restore_on = ~s_q.ctrl[swc_pkg::CTRL_SOFT_OFF] | (rec == swc_pkg::REC_ON) |
                      ((rec == swc_pkg::REC_LAST) & s_q.prev_on);

  // each source only counts in the states it supports, never when working
  always_comb begin
    wake                   = '0;
    wake[swc_pkg::EV_USB]  = USB_ACT_IN & in_set(s_q.state, SET_SLEEP_ACPI);
    wake[swc_pkg::EV_KBD]  = KBD_ACT_IN & in_set(s_q.state, SET_SLEEP_ACPI);
    wake[swc_pkg::EV_PME]  = (pme_any & in_set(s_q.state, SET_SLEEP_ACPI)) |
                             (pme_s5 & (s_q.state == swc_pkg::ST_OFF));
    wake[swc_pkg::EV_RTC]  = RTC_ALARM_IN & in_set(s_q.state, SET_ACPI_S5);
    // one ring level is enough; no ring counting
    wake[swc_pkg::EV_RING] = RING_IN & s_q.ctrl[swc_pkg::CTRL_MODEM_UNM] &
                             in_set(s_q.state, SET_RING);
    wake[swc_pkg::EV_NET]  = (NET_HDR_WAKE_IN & ~s_q.ctrl[swc_pkg::CTRL_ACPI] &
                              in_set(s_q.state, SET_ANY_SLEEP)) |
                             (NET_ONBOARD_WAKE_IN & s_q.ctrl[swc_pkg::CTRL_ACPI] &
                              s_q.ctrl[swc_pkg::CTRL_ONBOARD] & in_set(s_q.state, SET_ACPI_S5));
    wake[swc_pkg::EV_BTN]  = b.short_press & in_set(s_q.state, SET_ANY_SLEEP);
  end

  always_comb begin
    s_d       = s_q;
    s_d.rdata = 32'h0;

    // power state, mains loss first, then forced off, wakes, commands
    if (!MAINS_OK_IN) begin
      if (s_q.state != swc_pkg::ST_LOST) begin
        s_d.prev_on = (s_q.state != swc_pkg::ST_OFF);
        s_d.state   = swc_pkg::ST_LOST;
      end
    end else if (s_q.state == swc_pkg::ST_LOST) begin
      s_d.state = restore_on ? swc_pkg::ST_WORK : swc_pkg::ST_OFF;
    end else if (b.long_press && s_q.state != swc_pkg::ST_OFF) begin
      s_d.state = swc_pkg::ST_OFF;
    end else if (|wake) begin
      // memory is kept powered in S3, so resume goes straight to working
      s_d.state = swc_pkg::ST_WORK;
    end else if (b.short_press && s_q.state == swc_pkg::ST_WORK) begin
      s_d.state = s_q.ctrl[swc_pkg::CTRL_BTN_S3] ? swc_pkg::ST_S3 : swc_pkg::ST_S1;
    end else if (WR_IN && ADDR_IN == swc_pkg::OFS_CMD && s_q.state == swc_pkg::ST_WORK) begin
      case (WDATA_IN[2:0])
        swc_pkg::CMD_S1:     s_d.state = swc_pkg::ST_S1;
        swc_pkg::CMD_S3:     s_d.state = swc_pkg::ST_S3;
        swc_pkg::CMD_LEGACY: s_d.state = swc_pkg::ST_LEGACY;
        swc_pkg::CMD_OFF: begin
          if (s_q.ctrl[swc_pkg::CTRL_SOFT_OFF]) begin
            s_d.state = swc_pkg::ST_OFF;
          end
        end
        default:             s_d.state = s_q.state;
      endcase
    end

    // register writes
    if (WR_IN) begin
      case (ADDR_IN)
        swc_pkg::OFS_CTRL:   s_d.ctrl  = WDATA_IN[swc_pkg::CTRL_W-1:0];
        swc_pkg::OFS_EV_EN:  s_d.ev_en = WDATA_IN[swc_pkg::EV_W-1:0];
        default:             s_d.ctrl  = s_q.ctrl;
      endcase
    end

    // sticky events: a new event beats a clear in the same cycle
    s_d.ev_stat = s_q.ev_stat;
    if (WR_IN && ADDR_IN == swc_pkg::OFS_EV_CLR) begin
      s_d.ev_stat = s_q.ev_stat & ~WDATA_IN[swc_pkg::EV_W-1:0];
    end
    s_d.ev_stat = s_d.ev_stat | wake;
    if (MAINS_OK_IN && s_q.state == swc_pkg::ST_LOST) begin
      s_d.ev_stat[swc_pkg::EV_MAIN] = 1'b1;
    end

    // only processor and system fans have tach feedback
    s_d.cpu_tach = CPU_TACH_IN;
    s_d.sys_tach = SYS_TACH_IN;
    if (CPU_TACH_IN && !s_q.cpu_tach) begin
      s_d.cpu_cnt = s_q.cpu_cnt + 16'h1;
    end
    if (SYS_TACH_IN && !s_q.sys_tach) begin
      s_d.sys_cnt = s_q.sys_cnt + 16'h1;
    end

    // reads answer in the next cycle; unmapped reads return zero
    if (RD_IN) begin
      case (ADDR_IN)
        swc_pkg::OFS_CTRL:    s_d.rdata = {25'h0, s_q.ctrl};
        swc_pkg::OFS_STATE:   s_d.rdata = {24'h0, MAINS_OK_IN, s_q.prev_on, s_q.state};
        swc_pkg::OFS_EV_STAT: s_d.rdata = {24'h0, s_q.ev_stat};
        swc_pkg::OFS_EV_EN:   s_d.rdata = {24'h0, s_q.ev_en};
        swc_pkg::OFS_TACH:    s_d.rdata = {s_q.sys_cnt, s_q.cpu_cnt};
        default:              s_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      s_q <= RESET_S;
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA_OUT       = s_q.rdata;
  assign IRQ_OUT         = |(s_q.ev_stat & s_q.ev_en);
  assign PSU_ON_OUT      = in_set(s_q.state, SET_PSU_ON);
  assign SYS_FAN_OUT     = (s_q.state == swc_pkg::ST_WORK);
  assign CHASSIS_FAN_OUT = (s_q.state == swc_pkg::ST_WORK);
  assign LED_GREEN_OUT   = (s_q.state == swc_pkg::ST_WORK);
  // single-colour indicator stays dark in sleep
  assign LED_AMBER_OUT   = LED_DUAL_IN & in_set(s_q.state, SET_SLEEP_ACPI | swc_pkg::ST_LEGACY);

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  sequence mains_back;
    !MAINS_OK_IN ##1 MAINS_OK_IN;
  endsequence

  sequence quiet_sleep(logic src);
    MAINS_OK_IN && !b.long_press && src && in_set(s_q.state, SET_SLEEP_ACPI);
  endsequence

  // a command that no higher-priority event can pre-empt
  sequence cmd_in_work(logic [2:0] code);
    WR_IN && ADDR_IN == swc_pkg::OFS_CMD && WDATA_IN[2:0] == code && s_q.state == swc_pkg::ST_WORK &&
    MAINS_OK_IN && !b.long_press && !b.short_press;
  endsequence

  chk_usb_wake_s3: assert property (quiet_sleep(USB_ACT_IN) |=> s_q.state == swc_pkg::ST_WORK)
    else $error("usb activity did not wake from S1/S3");
  chk_kbd_wake_s3: assert property (quiet_sleep(KBD_ACT_IN) |=> SYS_FAN_OUT && PSU_ON_OUT)
    else $error("keyboard activity did not wake from S1/S3");
  chk_usb_off_ignored: assert property (s_q.state == swc_pkg::ST_OFF |-> !wake[swc_pkg::EV_USB])
    else $error("usb taken as wake from soft-off");
  chk_pme_slot_two: assert property (MAINS_OK_IN && !b.long_press && s_q.state == swc_pkg::ST_OFF && pme_s5
                                     |=> s_q.state == swc_pkg::ST_WORK)
    else $error("slot two PME did not wake from soft-off");
  chk_rtc_wake_off: assert property (MAINS_OK_IN && !b.long_press && RTC_ALARM_IN &&
                                     s_q.state == swc_pkg::ST_OFF |=> PSU_ON_OUT)
    else $error("rtc alarm did not wake from soft-off");
  chk_ring_masked: assert property (!s_q.ctrl[swc_pkg::CTRL_MODEM_UNM] |-> !wake[swc_pkg::EV_RING])
    else $error("ring wake while modem interrupt masked");
  chk_softoff_gate: assert property (cmd_in_work(swc_pkg::CMD_OFF) ##0 !s_q.ctrl[swc_pkg::CTRL_SOFT_OFF]
                                     |=> PSU_ON_OUT)
    else $error("power-off command obeyed without soft-off enable");
  chk_s3_outputs: assert property (s_q.state == swc_pkg::ST_S3 |-> !PSU_ON_OUT && !SYS_FAN_OUT &&
                                   !CHASSIS_FAN_OUT && LED_AMBER_OUT == LED_DUAL_IN)
    else $error("wrong supply, fan or indicator in S3");
  chk_work_no_wake: assert property (s_q.state == swc_pkg::ST_WORK |-> wake == '0)
    else $error("wake source taken while working");
  // from soft-off a long press is no forcing event, so a wake in that cycle may still win
  chk_long_forces_off: assert property (MAINS_OK_IN && b.long_press &&
                                        !in_set(s_q.state, swc_pkg::ST_LOST | swc_pkg::ST_OFF)
                                        |=> s_q.state == swc_pkg::ST_OFF && !PSU_ON_OUT)
    else $error("long press did not force soft-off");
  chk_mains_restore: assert property (mains_back ##0 (rec == swc_pkg::REC_OFF) ##0
                                      s_q.ctrl[swc_pkg::CTRL_SOFT_OFF]
                                      |=> s_q.state == swc_pkg::ST_OFF && s_q.ev_stat[swc_pkg::EV_MAIN])
    else $error("mains restore ignored stay-off policy");

  chk_softoff_taken: assert property (cmd_in_work(swc_pkg::CMD_OFF) ##0 s_q.ctrl[swc_pkg::CTRL_SOFT_OFF]
                                      |=> s_q.state == swc_pkg::ST_OFF && !PSU_ON_OUT)
    else $error("power-off command with soft-off enabled left supply on");
  chk_cmd_enter_s3: assert property (cmd_in_work(swc_pkg::CMD_S3)
                                     |=> s_q.state == swc_pkg::ST_S3 && !PSU_ON_OUT && !SYS_FAN_OUT)
    else $error("sleep command did not reach S3 with supply and fan off");
  chk_ring_s1_wake: assert property (MAINS_OK_IN && !b.long_press && RING_IN &&
                                     s_q.ctrl[swc_pkg::CTRL_MODEM_UNM] && s_q.state == swc_pkg::ST_S1
                                     |=> s_q.state == swc_pkg::ST_WORK)
    else $error("ring did not wake from S1");
  chk_ring_s3_ignored: assert property (s_q.state == swc_pkg::ST_S3 |-> !wake[swc_pkg::EV_RING])
    else $error("ring taken as wake from S3");
  chk_hdr_net_legacy: assert property (MAINS_OK_IN && !b.long_press && NET_HDR_WAKE_IN &&
                                       !s_q.ctrl[swc_pkg::CTRL_ACPI] && s_q.state == swc_pkg::ST_LEGACY
                                       |=> s_q.state == swc_pkg::ST_WORK && PSU_ON_OUT)
    else $error("network wake header did not wake from legacy sleep");
  chk_hdr_net_acpi: assert property (s_q.ctrl[swc_pkg::CTRL_ACPI] && !NET_ONBOARD_WAKE_IN
                                     |-> !wake[swc_pkg::EV_NET])
    else $error("network wake header taken in advanced configuration mode");
  chk_short_wakes: assert property (MAINS_OK_IN && !b.long_press && b.short_press &&
                                    in_set(s_q.state, SET_ANY_SLEEP)
                                    |=> s_q.state == swc_pkg::ST_WORK && s_q.ev_stat[swc_pkg::EV_BTN])
    else $error("short press did not wake the system");
  chk_short_sleeps: assert property (MAINS_OK_IN && b.short_press && s_q.state == swc_pkg::ST_WORK
                                     |=> in_set(s_q.state, SET_SLEEP_ACPI) && !SYS_FAN_OUT)
    else $error("short press did not put the system to sleep");
  chk_fans_follow: assert property (s_q.state != swc_pkg::ST_WORK |-> !SYS_FAN_OUT && !CHASSIS_FAN_OUT)
    else $error("fan supply on outside working state");
  chk_lost_dark: assert property (s_q.state == swc_pkg::ST_LOST
                                  |-> !PSU_ON_OUT && !LED_GREEN_OUT && !LED_AMBER_OUT)
    else $error("outputs active while mains is lost");
  chk_mains_loss: assert property (!MAINS_OK_IN |=> s_q.state == swc_pkg::ST_LOST && !PSU_ON_OUT)
    else $error("mains loss did not drop to the lost state");
  chk_event_sticky: assert property ((wake != '0) |=> (s_q.ev_stat & $past(wake)) == $past(wake))
    else $error("wake event not latched in status");
  chk_rdata_idle: assert property (!RD_IN |=> RDATA_OUT == 32'h0)
    else $error("read data outside the answer cycle");

endmodule : sleep_wake_event_control

// ===== sim/wake_source_model.sv
module wake_source_model (
  // clock
  input  wire logic       clk_in,
  // request from the bench
  input  wire logic       go_in,
  input  wire logic [2:0] sel_in,
  // wake source levels: usb, kbd, pme0, pme1, rtc, ring, header net, onboard net
  output logic      [7:0] src_out = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;

  // one cycle of level is all a real source promises, so the block must catch it at once
  // a wake frame seen on the wire becomes a one-cycle wakeup level
  // a ring is one call only, never repeated
  always @(posedge clk_in) begin
    src_out <= go_in ? (8'h01 << sel_in) : 8'h00;
  end
endmodule : wake_source_model

// ===== sim/sleep_wake_event_control_bench.sv
module sleep_wake_event_control_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [2:0] C1 = swc_pkg::CMD_S1;
  localparam logic [2:0] C3 = swc_pkg::CMD_S3;
  localparam logic [2:0] CO = swc_pkg::CMD_OFF;
  localparam logic [2:0] CL = swc_pkg::CMD_LEGACY;
  localparam logic [5:0] W  = swc_pkg::ST_WORK;
  // {command, source, wakes}
  localparam logic [6:0] TBL [15] = '{{C1, 3'd0, 1'b1}, {C3, 3'd0, 1'b1}, {C1, 3'd1, 1'b1},
    {C3, 3'd1, 1'b1}, {C1, 3'd2, 1'b1}, {C3, 3'd2, 1'b1}, {C1, 3'd4, 1'b1}, {C3, 3'd4, 1'b1},
    {C3, 3'd5, 1'b0}, {C1, 3'd5, 1'b1}, {CL, 3'd5, 1'b1}, {CL, 3'd0, 1'b0}, {CL, 3'd4, 1'b0},
    {C3, 3'd6, 1'b0}, {C3, 3'd7, 1'b0}};

  typedef struct {logic [31:0] d; logic [31:0] m;} note_type;

  logic        clk;
  logic        rstn, wr_s, rd_s, rd_pend, go_s, btn_n, mains, led_dual, ctach, stach;
  logic        psu, sfan, cfan, lg, la, irq;
  logic [7:0]  addr, src;
  logic [2:0]  sel;
  logic [31:0] wdata, rdata, rnd;
  note_type    notes[$];
  int          num_errors, samples_checked;

  sleep_wake_event_control #(.BTN_LONG_CYCLES(20), .NUM_PME_SLOTS(4)) i_sleep_wake_event_control (
    .CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s),
    .RDATA_OUT(rdata), .USB_ACT_IN(src[0]), .KBD_ACT_IN(src[1]), .PME_N_IN(~{2'b00, src[3:2]}),
    .RTC_ALARM_IN(src[4]), .RING_IN(src[5]), .NET_HDR_WAKE_IN(src[6]), .NET_ONBOARD_WAKE_IN(src[7]),
    .PWR_BTN_N_IN(btn_n), .MAINS_OK_IN(mains), .LED_DUAL_IN(led_dual), .CPU_TACH_IN(ctach),
    .SYS_TACH_IN(stach), .PSU_ON_OUT(psu), .SYS_FAN_OUT(sfan), .CHASSIS_FAN_OUT(cfan),
    .LED_GREEN_OUT(lg), .LED_AMBER_OUT(la), .IRQ_OUT(irq));

  wake_source_model i_wake_source_model (.clk_in(clk), .go_in(go_s), .sel_in(sel), .src_out(src));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [5:0] st_of(input logic [2:0] c);
    case (c)
      C1: return swc_pkg::ST_S1;
      C3: return swc_pkg::ST_S3;
      CL: return swc_pkg::ST_LEGACY;
      default: return swc_pkg::ST_OFF;
    endcase
  endfunction : st_of

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("errors %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr

  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    notes.push_back('{e, m});
    @(posedge clk);
    rd_s <= 1'b0;
  endtask : rd_exp

  task automatic st(input logic [5:0] e);
    rd_exp(swc_pkg::OFS_STATE, {26'h0, e}, 32'h3F);
  endtask : st

  task automatic go(input logic [2:0] c);
    wr(swc_pkg::OFS_CMD, {29'h0, c});
    repeat (2) @(posedge clk);
  endtask : go

  task automatic wake(input logic [2:0] s);
    @(posedge clk);
    sel  <= s;
    go_s <= 1'b1;
    @(posedge clk);
    go_s <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : wake

  task automatic press(input int n);
    @(posedge clk);
    btn_n <= 1'b0;
    repeat (n) @(posedge clk);
    btn_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : press

  task automatic power(input logic v);
    @(posedge clk);
    mains <= v;
    repeat (3) @(posedge clk);
  endtask : power

  // outputs are sampled mid-cycle so the edge's updates have landed
  task automatic pins(input logic [4:0] e);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({27'h0, psu, sfan, cfan, lg, la}, {27'h0, e});
    @(posedge clk);
  endtask : pins

  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({31'h0, irq}, {31'h0, e});
    @(posedge clk);
  endtask : irq_is

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) rd_pend <= rd_s;

  // read data stand only in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_pend === 1'b1) begin
      note_type n;
      n = notes.pop_front();
      check(rdata & n.m, n.d);
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    {rstn, wr_s, rd_s, go_s, ctach, stach} = '0;
    {btn_n, mains, led_dual} = 3'b111;
    addr = 8'h00;
    wdata = 32'h0;
    sel = 3'd0;
    rnd = 32'h98A16C2F;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    st(W);
    rd_exp(swc_pkg::OFS_CTRL, 32'h0A, 32'h7F);
    rd_exp(swc_pkg::OFS_EV_STAT, 32'h80, 32'h80);
    pins(5'b11110);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      ctach <= (k < 3);
      stach <= 1'b1;
      @(posedge clk);
      {ctach, stach} <= 2'b00;
    end
    repeat (2) @(posedge clk);
    rd_exp(swc_pkg::OFS_TACH, 32'h0005_0003, '1);
    foreach (TBL[i]) begin
      go(TBL[i][6:4]);
      wake(TBL[i][3:1]);
      st(TBL[i][0] ? W : st_of(TBL[i][6:4]));
      if (!TBL[i][0]) wake(TBL[i][6:4] == CL ? 3'd5 : 3'd4);
    end
    go(C3);
    pins(5'b00001);
    led_dual <= 1'b0;
    pins(5'b00000);
    wake(3'd0);
    pins(5'b11110);
    led_dual <= 1'b1;
    wr(swc_pkg::OFS_CTRL, 32'h02);
    go(C1);
    wake(3'd5);
    st(swc_pkg::ST_S1);
    wake(3'd4);
    wr(swc_pkg::OFS_CTRL, 32'h06);
    go(C3);
    wake(3'd7);
    st(W);
    wr(swc_pkg::OFS_CTRL, 32'h08);
    go(CL);
    wake(3'd6);
    st(W);
    wr(swc_pkg::OFS_CTRL, 32'h0A);
    go(CO);
    st(W);
    wr(swc_pkg::OFS_CTRL, 32'h0B);
    go(CO);
    st(swc_pkg::ST_OFF);
    pins(5'b00000);
    wake(3'd0);
    wake(3'd2);
    st(swc_pkg::ST_OFF);
    wake(3'd3);
    st(W);
    go(CO);
    power(1'b0);
    st(swc_pkg::ST_LOST);
    power(1'b1);
    st(swc_pkg::ST_OFF);
    wr(swc_pkg::OFS_CTRL, 32'h2B);
    power(1'b0);
    power(1'b1);
    st(W);
    wr(swc_pkg::OFS_CTRL, 32'h4B);
    power(1'b0);
    power(1'b1);
    st(W);
    wr(swc_pkg::OFS_CTRL, 32'h0A);
    press(5);
    st(swc_pkg::ST_S1);
    press(5);
    st(W);
    wr(swc_pkg::OFS_CTRL, 32'h1A);
    press(5);
    st(swc_pkg::ST_S3);
    press(5);
    press(25);
    st(swc_pkg::ST_OFF);
    wake(3'd4);
    wr(swc_pkg::OFS_EV_CLR, '1);
    rd_exp(swc_pkg::OFS_EV_STAT, 32'h0, '1);
    rnd = lfsr(rnd);
    wr(swc_pkg::OFS_EV_EN, rnd & 32'hFE);
    go(C1);
    wake(3'd0);
    irq_is(1'b0);
    wr(swc_pkg::OFS_EV_EN, 32'h01);
    irq_is(1'b1);
    rd_exp(swc_pkg::OFS_EV_EN, 32'h01, 32'hFF);
    wr(swc_pkg::OFS_EV_CLR, 32'h01);
    irq_is(1'b0);
    rnd = lfsr(rnd);
    wr(8'h1C, rnd);
    rd_exp(8'h1C, 32'h0, '1);
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule : sleep_wake_event_control_bench
